// >>> logic/drpm_top.sv
// Purpose: Per-rank power management of one DDR5 channel (two ranks)
// Assumes: Scheduler, refresh timer and power controller are on i_clk_sys
// Notes:   The DRAM clock is sampled as a pin; idle counts run on its rising edges
`timescale 1ns/100ps

module drpm_top
   import drpm_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   input wire logic i_dram_clk,
   input wire logic [1:0] i_powerdown_config_setting,
   input wire logic [`DRPM_CNT_W-1:0] i_idle_thresh,
   input wire logic i_idle_thresh_wr,
   input wire logic i_reg_lock,
   input wire logic [`DRPM_RANKS-1:0] i_rank_unused,
   input wire logic i_cs_tristate_en,
   input wire logic [`DRPM_CST_W-1:0] i_pkg_cstate,
   input wire logic i_suspend_req,
   input wire logic i_flush_done,
   input wire logic [`DRPM_RANKS-1:0] i_gfx_rank,
   input wire logic i_io_supply_gating,
   input wire logic [`DRPM_RANKS-1:0] i_pending,
   input wire logic [`DRPM_RANKS-1:0] i_banks_precharged,
   input wire logic i_refresh_req,
   input wire logic i_refresh_done,
   input wire logic i_req_valid,
   input wire drpm_cmd_type i_req,
   output logic o_req_ready,
   output logic o_refresh_grant,
   output logic [`DRPM_RANKS-1:0] o_precharge_all,
   output logic o_flush_req,
   output logic o_train_reload,
   output drpm_pins_type o_pins,
   output logic [`DRPM_RANKS-1:0] o_ck_p,
   output logic [`DRPM_RANKS-1:0] o_ck_n,
   output logic [`DRPM_CA_W-1:0] o_ca,
   output logic [`DRPM_RANKS-1:0] o_rx_en,
   output drpm_rank_state_type o_rank_state [`DRPM_RANKS]
);

   // ==========================================================
   // Helper functions
   // Deep package state test, shared by self-refresh entry and exit
   function automatic logic deep_idle(input logic [`DRPM_CST_W-1:0] cst);
      deep_idle = (cst >= `DRPM_CST_C3);
   endfunction

   // A rank is usable when present or when tristating has not been allowed
   function automatic logic rank_live(input logic unused, input logic tri_en);
      rank_live = !(unused && tri_en);
   endfunction

   localparam logic [7:0] EXIT_CYC = 8'(`DRPM_EXIT_CYC);

   // ==========================================================
   // DRAM clock sampling and edge detection
   logic dram_clock_cycle_s1_r;
   logic dram_clock_cycle_s2_r;
   logic dram_clock_cycle_s3_r;
   logic dram_clock_cycle_rise;

   // Two stages before any logic looks at the pin
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         dram_clock_cycle_s1_r <= 1'b0;
         dram_clock_cycle_s2_r <= 1'b0;
         dram_clock_cycle_s3_r <= 1'b0;
      end else if (i_clk_en) begin
         dram_clock_cycle_s1_r <= i_dram_clk;
         dram_clock_cycle_s2_r <= dram_clock_cycle_s1_r;
         dram_clock_cycle_s3_r <= dram_clock_cycle_s2_r;
      end
   end

   assign dram_clock_cycle_rise = dram_clock_cycle_s2_r && !dram_clock_cycle_s3_r;

   // ==========================================================
   // Idle threshold setting
   logic [`DRPM_CNT_W-1:0] thresh_r;

   // Locked writes are dropped silently; software cannot see the refusal
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         thresh_r <= `DRPM_THRESH_RST;
      end else if (i_clk_en && i_idle_thresh_wr && !i_reg_lock) begin
         thresh_r <= i_idle_thresh;
      end
   end

   // ==========================================================
   // Self-refresh sequencing (channel wide)
   typedef enum logic [1:0] {
      SR_RUN,
      SR_FLUSH,
      SR_IN
   } drpm_sr_type;

   drpm_sr_type sr_r;
   logic sr_want;
   logic sr_enter;
   logic sr_leave;

   // Deep idle with an empty queue, or a suspend request, asks for it
   assign sr_want = i_suspend_req ||
                    (deep_idle(i_pkg_cstate) && (i_pending == '0) && !i_req_valid);
   assign sr_enter = (sr_r == SR_FLUSH) && i_flush_done;
   assign sr_leave = (sr_r == SR_IN) && !sr_want;

   // Flush must finish before any rank drops into self-refresh
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         sr_r <= SR_RUN;
      end else if (i_clk_en) begin
         case (sr_r)
            SR_RUN: begin
               if (sr_want && !i_refresh_req) begin
                  sr_r <= SR_FLUSH;
               end
            end
            SR_FLUSH: begin
               if (!sr_want) begin
                  sr_r <= SR_RUN;
               end else if (i_flush_done) begin
                  sr_r <= SR_IN;
               end
            end
            SR_IN: begin
               if (!sr_want) begin
                  sr_r <= SR_RUN;
               end
            end
            default: begin
               sr_r <= SR_RUN;
            end
         endcase
      end
   end

   assign o_flush_req = (sr_r == SR_FLUSH);

   // Stored training results are reloaded instead of retraining
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_train_reload <= 1'b0;
      end else if (i_clk_en) begin
         o_train_reload <= sr_leave;
      end
   end

   // ==========================================================
   // Refresh window
   logic ref_busy_r;
   logic all_awake;
   logic [`DRPM_RANKS-1:0] awake;

   // Held from grant until the refresh timer reports completion
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         ref_busy_r <= 1'b0;
      end else if (i_clk_en) begin
         if (i_refresh_done) begin
            ref_busy_r <= 1'b0;
         end else if (i_refresh_req && all_awake && (sr_r == SR_RUN)) begin
            ref_busy_r <= 1'b1;
         end
      end
   end

   assign all_awake = (awake == '1);
   assign o_refresh_grant = ref_busy_r;

   // ==========================================================
   // Per-rank idle counters and power states
   drpm_rank_state_type st_r [`DRPM_RANKS];
   logic [`DRPM_CNT_W-1:0] idle_r [`DRPM_RANKS];
   logic [7:0] exit_r [`DRPM_RANKS];
   logic [`DRPM_RANKS-1:0] repd_r;
   logic [`DRPM_RANKS-1:0] cke_r;
   logic [`DRPM_RANKS-1:0] new_work;
   logic [`DRPM_RANKS-1:0] expired;
   logic pd_on;

   assign pd_on = (i_powerdown_config_setting != `DRPM_PD_NONE);
   for (genvar g = 0; g < `DRPM_RANKS; g++) begin : g_rank
      // New queue entries or a waiting request count as activity
      assign new_work[g] = i_pending[g] || (i_req_valid && (i_req.rank == 1'(g)));
      assign expired[g] = (idle_r[g] >= thresh_r);
      assign awake[g] = (st_r[g] == RANK_ACTIVE) || !rank_live(i_rank_unused[g],
                        i_cs_tristate_en);

      // Counts rising DRAM clock edges of inactivity, saturating at its top
      always_ff @(posedge i_clk_sys) begin
         if (i_sys_rst) begin
            idle_r[g] <= '0;
         end else if (i_clk_en) begin
            if (new_work[g] || st_r[g] != RANK_ACTIVE) begin
               idle_r[g] <= '0;
            end else if (dram_clock_cycle_rise && idle_r[g] != '1) begin
               idle_r[g] <= idle_r[g] + 1'b1;
            end
         end
      end

      // Remembers ranks that were down when a refresh woke them
      always_ff @(posedge i_clk_sys) begin
         if (i_sys_rst) begin
            repd_r[g] <= 1'b0;
         end else if (i_clk_en) begin
            if (i_refresh_req && st_r[g] == RANK_PD) begin
               repd_r[g] <= 1'b1;
            end else if (i_refresh_done) begin
               repd_r[g] <= 1'b0;
            end
         end
      end

      // Rank power state machine
      always_ff @(posedge i_clk_sys) begin
         if (i_sys_rst) begin
            st_r[g] <= RANK_ACTIVE;
            exit_r[g] <= '0;
         end else if (i_clk_en) begin
            case (st_r[g])
               RANK_ACTIVE: begin
                  if (sr_enter && !i_gfx_rank[g]) begin
                     st_r[g] <= RANK_SR;
                  end else if (pd_on && i_refresh_done && repd_r[g] && !new_work[g]) begin
                     st_r[g] <= RANK_PD;
                  end else if (pd_on && expired[g] && !new_work[g] &&
                               !i_refresh_req && !ref_busy_r) begin
                     if (i_powerdown_config_setting == `DRPM_PD_PRECHARGE) begin
                        st_r[g] <= RANK_CLOSE;
                     end else begin
                        st_r[g] <= RANK_PD;
                     end
                  end
               end
               RANK_CLOSE: begin
                  if (new_work[g] || i_refresh_req) begin
                     st_r[g] <= RANK_ACTIVE;
                  end else if (i_banks_precharged[g]) begin
                     st_r[g] <= RANK_PD;
                  end
               end
               RANK_PD: begin
                  if (new_work[g] || i_refresh_req || sr_enter) begin
                     st_r[g] <= RANK_EXIT;
                     exit_r[g] <= EXIT_CYC;
                  end
               end
               RANK_EXIT: begin
                  if (exit_r[g] <= 8'h01) begin
                     st_r[g] <= RANK_ACTIVE;
                  end else begin
                     exit_r[g] <= exit_r[g] - 1'b1;
                  end
               end
               RANK_SR: begin
                  if (sr_leave) begin
                     st_r[g] <= RANK_EXIT;
                     exit_r[g] <= EXIT_CYC;
                  end
               end
               default: begin
                  st_r[g] <= RANK_ACTIVE;
               end
            endcase
         end
      end

      // Clock-enable is frozen while the I/O supply is gated
      always_ff @(posedge i_clk_sys) begin
         if (i_sys_rst) begin
            cke_r[g] <= 1'b1;
         end else if (i_clk_en && !i_io_supply_gating) begin
            cke_r[g] <= (st_r[g] == RANK_ACTIVE) || (st_r[g] == RANK_CLOSE) ||
                        (st_r[g] == RANK_EXIT);
         end
      end

      // Close-all-pages request while waiting for the banks
      assign o_precharge_all[g] = (st_r[g] == RANK_CLOSE);
      assign o_rank_state[g] = st_r[g];
   end

   // ==========================================================
   // Command issue
   logic [`DRPM_RANKS-1:0] cs_n_r;
   logic [`DRPM_CA_W-1:0] ca_r;
   logic issue;

   // Only an awake rank outside refresh and self-refresh takes a command
   assign o_req_ready = (st_r[i_req.rank] == RANK_ACTIVE) && !ref_busy_r &&
                        !i_refresh_req && (sr_r == SR_RUN);
   assign issue = i_req_valid && o_req_ready;

   // Chip-select low for one cycle on the addressed rank
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         cs_n_r <= '1;
         ca_r <= `DRPM_CA_IDLE;
      end else if (i_clk_en) begin
         cs_n_r <= '1;
         if (issue) begin
            cs_n_r[i_req.rank] <= 1'b0;
            ca_r <= i_req.ca;
         end
      end
   end

   assign o_ca = ca_r;

   // ==========================================================
   // Per-rank pin drivers
   logic [`DRPM_RANKS-1:0] live;
   logic [`DRPM_RANKS-1:0] ck_r;

   // Forwarded rank clock, parked low when the rank is not driven
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         ck_r <= '0;
      end else if (i_clk_en) begin
         ck_r <= {`DRPM_RANKS{dram_clock_cycle_s2_r}} & live;
      end
   end

   // Unused ranks only float once software allows it, even while in reset
   always_comb begin
      for (int r = 0; r < `DRPM_RANKS; r++) begin
         live[r] = rank_live(i_rank_unused[r], i_cs_tristate_en);
      end
   end

   assign o_ck_p = ck_r;
   assign o_ck_n = ~ck_r & live;
   assign o_rx_en = live;
   assign o_pins.cke = cke_r;
   assign o_pins.cs_n = cs_n_r;
   assign o_pins.cs_oe = live;
   assign o_pins.ck_oe = live;

endmodule // drpm_top

// >>> common/drpm_map.svh
// Purpose: Constants of the DRAM rank power manager
// Assumes: System clock of 100 MHz
// Notes:   Definitions only
`ifndef DRPM_MAP_SVH
`define DRPM_MAP_SVH

// ==========================================================
// Sizes
`define DRPM_RANKS 2
`define DRPM_CA_W 13
`define DRPM_CNT_W 16
`define DRPM_CST_W 4

// ==========================================================
// Power-down configuration encodings
`define DRPM_PD_NONE 2'h0
`define DRPM_PD_ACTIVE 2'h1
`define DRPM_PD_PRECHARGE 2'h2

// ==========================================================
// Package state thresholds and reset values
`define DRPM_CST_C3 4'h3
`define DRPM_THRESH_RST 16'h0040
`define DRPM_CA_IDLE 13'h1fff

// ==========================================================
// Timing: power-down exit latency in ns and its cycle count
`define DRPM_SYS_MHZ 100
`define DRPM_EXIT_NS 8
`define DRPM_EXIT_CYC ((`DRPM_EXIT_NS * `DRPM_SYS_MHZ + 999) / 1000)

`endif

// >>> common/drpm_pkg.sv
// Purpose: Types of the DRAM rank power manager
// Assumes: Constants come from drpm_map.svh
// Notes:   Types only
`include "drpm_map.svh"

package drpm_pkg;

   // Per-rank power state
   typedef enum logic [2:0] {
      RANK_ACTIVE,
      RANK_CLOSE,
      RANK_PD,
      RANK_EXIT,
      RANK_SR
   } drpm_rank_state_type;

   // Command handed in by the scheduler
   typedef struct packed {
      logic rank;
      logic [`DRPM_CA_W-1:0] ca;
   } drpm_cmd_type;

   // Pins of all ranks seen at the DRAM side
   typedef struct packed {
      logic [`DRPM_RANKS-1:0] cke;
      logic [`DRPM_RANKS-1:0] cs_n;
      logic [`DRPM_RANKS-1:0] cs_oe;
      logic [`DRPM_RANKS-1:0] ck_oe;
   } drpm_pins_type;

endpackage

// >>> testbench/drpm_sva.sv
// Purpose: Port assertions of the rank power manager
// Assumes: One clock domain with synchronous reset
// Notes:   Bound to every drpm_top; rank 0 carries the state checks
`timescale 1ns/100ps
`include "drpm_map.svh"

module drpm_sva
   import drpm_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   input wire logic [1:0] i_powerdown_config_setting,
   input wire logic [`DRPM_RANKS-1:0] i_rank_unused,
   input wire logic i_cs_tristate_en,
   input wire logic i_flush_done,
   input wire logic [`DRPM_RANKS-1:0] i_gfx_rank,
   input wire logic i_io_supply_gating,
   input wire logic [`DRPM_RANKS-1:0] i_banks_precharged,
   input wire logic i_req_valid,
   input wire drpm_cmd_type i_req,
   input wire logic o_req_ready,
   input wire logic o_flush_req,
   input wire drpm_pins_type o_pins,
   input wire logic [`DRPM_CA_W-1:0] o_ca,
   input wire logic [`DRPM_RANKS-1:0] o_rx_en,
   input wire drpm_rank_state_type o_rank_state [`DRPM_RANKS]
);
   // ==========================================================
   // Checks on power-down, self-refresh and pin control
   // One domain, so clock and reset are given once
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   chk_no_pd_mode: assert property ($past(o_rank_state[0]) == RANK_ACTIVE &&
      o_rank_state[0] == RANK_PD |-> $past(i_powerdown_config_setting) != 2'h0)
      else $error("power-down entered with mode none");
   chk_close_done: assert property ($past(o_rank_state[0]) == RANK_CLOSE &&
      o_rank_state[0] == RANK_PD |-> $past(i_banks_precharged[0]))
      else $error("precharge power-down with open banks");
   chk_exit_wait: assert property ($past(o_rank_state[0]) == RANK_PD &&
      o_rank_state[0] != RANK_PD |-> o_rank_state[0] == RANK_EXIT ##1
      o_rank_state[0] == RANK_ACTIVE)
      else $error("power-down exit latency broken");
   chk_issue_cmd: assert property (i_req_valid && o_req_ready && i_clk_en |=>
      !o_pins.cs_n[$past(i_req.rank)] && o_ca == $past(i_req.ca))
      else $error("command not issued on chip-select and bus");
   chk_sr_flush: assert property ($past(o_rank_state[0]) != RANK_SR &&
      o_rank_state[0] == RANK_SR |-> $past(o_flush_req && i_flush_done && !i_gfx_rank[0]))
      else $error("self-refresh entered without flush");
   chk_sr_cke: assert property ($past(o_rank_state[0]) == RANK_SR &&
      o_rank_state[0] == RANK_SR |-> !o_pins.cke[0])
      else $error("clock-enable high in self-refresh");
   chk_unused_off: assert property (i_rank_unused[1] && i_cs_tristate_en |->
      !o_pins.cs_oe[1] && !o_pins.ck_oe[1] && !o_rx_en[1])
      else $error("unused rank still driven");
   chk_gate_cke: assert property (i_io_supply_gating && $past(i_io_supply_gating) |->
      $stable(o_pins.cke))
      else $error("clock-enable moved during supply gating");
endmodule // drpm_sva

bind drpm_top drpm_sva i_sva (.*);

// >>> testbench/drpm_rank_model.sv
// Purpose: Behavioural DRAM ranks answering precharge-all
// Assumes: Banks close two cycles after precharge-all is seen
// Notes:   Any command to a rank reopens a row in it
`timescale 1ns/100ps
`include "drpm_map.svh"

module drpm_rank_model
   import drpm_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic [`DRPM_RANKS-1:0] i_precharge_all,
   input wire drpm_pins_type i_pins,
   output logic [`DRPM_RANKS-1:0] o_banks_precharged
);
   // ==========================================================
   // Bank state: unknown rows are taken as open after reset
   logic [`DRPM_RANKS-1:0] pre_r;
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         pre_r <= '0;
         o_banks_precharged <= '0;
      end else begin
         pre_r <= i_precharge_all;
         o_banks_precharged <= (o_banks_precharged | pre_r) & i_pins.cs_n;
      end
   end
endmodule // drpm_rank_model

// >>> testbench/tb_dram_rank_power_manager.sv
// Purpose: Self-checking bench of the rank power manager
// Assumes: 100 MHz system clock, DRAM clock pin of 80 ns
// Notes:   Inputs change on the falling edge
`timescale 1ns/100ps

module tb_dram_rank_power_manager;
   import drpm_pkg::*;
   // ==========================================================
   // Stimulus and observed signals
   logic clk = 0, rst = 1, dram_clock_cycle = 0, twr = 0, lock = 0, tsen = 0, susp = 0, cen = 1;
   logic fdone = 0, gate = 0, rreq = 0, rdone = 0, vld = 0, rdy, gnt, flq, trl;
   logic [1:0] pdm = '0, unu = '0, gfx = '0, pend = '0, bpc, pca, ckp, ckn, rxe;
   logic [15:0] thr = 16'h0040;
   logic [3:0] cst = '0;
   logic [12:0] ca;
   drpm_cmd_type req = '0;
   drpm_pins_type pins;
   drpm_rank_state_type st [2];
   int error_cnt = 0, num_checks = 0, cyc = 0, trl_cnt = 0;

   // Clocks; the DRAM clock is offset 3 ns so its edges never line up with ours
   always #5 clk = ~clk;
   initial #3 forever #40 dram_clock_cycle = ~dram_clock_cycle;

   drpm_top i_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(cen), .i_dram_clk(dram_clock_cycle),
      .i_powerdown_config_setting(pdm), .i_idle_thresh(thr), .i_idle_thresh_wr(twr),
      .i_reg_lock(lock), .i_rank_unused(unu), .i_cs_tristate_en(tsen), .i_pkg_cstate(cst),
      .i_suspend_req(susp), .i_flush_done(fdone), .i_gfx_rank(gfx),
      .i_io_supply_gating(gate), .i_pending(pend), .i_banks_precharged(bpc),
      .i_refresh_req(rreq), .i_refresh_done(rdone), .i_req_valid(vld), .i_req(req),
      .o_req_ready(rdy), .o_refresh_grant(gnt), .o_precharge_all(pca), .o_flush_req(flq),
      .o_train_reload(trl), .o_pins(pins), .o_ck_p(ckp), .o_ck_n(ckn), .o_ca(ca),
      .o_rx_en(rxe), .o_rank_state(st));
   drpm_rank_model i_ranks (.i_clk_sys(clk), .i_sys_rst(rst), .i_precharge_all(pca),
      .i_pins(pins), .o_banks_precharged(bpc));

   // Watchdog and reload-pulse counter; the run needs under 1000 cycles
   always @(negedge clk) begin
      cyc++;
      // Read mid-cycle, while the one-cycle pulse stands
      if (trl === 1'b1) begin
         trl_cnt++;
      end
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end

   // ==========================================================
   // Access tasks
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Waits a bounded time for a rank state, then compares it
   task automatic wst(input int r, input drpm_rank_state_type s);
      int n;
      n = 0;
      while (st[r] !== s && n < 300) begin
         @(negedge clk);
         n++;
      end
      chk(st[r], s);
   endtask
   // One command; a leading edge keeps back-to-back calls legal
   task automatic issue(input logic r, input logic [12:0] c);
      int n;
      n = 0;
      @(negedge clk);
      req.rank = r;
      req.ca = c;
      vld = 1;
      #1;
      while (rdy !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      vld = 0;
      chk(pins.cs_n[r], 1'b0);
      chk(ca, c);
   endtask
   task automatic twrite(input logic [15:0] v);
      thr = v;
      twr = 1;
      @(negedge clk);
      twr = 0;
   endtask

   // ==========================================================
   // Test sequence
   initial begin
      int n;
      repeat (10) @(negedge clk);
      rst = 0;
      @(negedge clk);
      chk(pins.cke, 2'h3);
      chk(pins.cs_n, 2'h3);
      chk(ca, 13'h1fff);
      chk(pins.cs_oe, 2'h3);
      repeat (100) @(negedge clk);
      chk(st[0], RANK_ACTIVE);
      issue(1'b0, 13'h0123);
      issue(1'b1, 13'h1abc);
      $display("test reset and issue done");
      twrite(16'h0004);
      pdm = 2'h1;
      // Clock enable low freezes the idle count, so no rank may power down
      cen = 0;
      repeat (60) @(negedge clk);
      chk(st[1], RANK_ACTIVE);
      cen = 1;
      wst(1, RANK_PD);
      issue(1'b0, 13'h0042);
      repeat (16) @(negedge clk);
      chk(st[0], RANK_ACTIVE);
      wst(0, RANK_PD);
      @(negedge clk);
      chk(pins.cke, 2'h0);
      lock = 1;
      twrite(16'hffff);
      issue(1'b0, 13'h0055);
      wst(0, RANK_PD);
      lock = 0;
      twrite(16'h0008);
      issue(1'b0, 13'h0066);
      repeat (40) @(negedge clk);
      chk(st[0], RANK_ACTIVE);
      wst(0, RANK_PD);
      $display("test idle threshold done");
      rreq = 1;
      n = 0;
      while (gnt !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      chk(gnt, 1'b1);
      chk(st[0], RANK_ACTIVE);
      chk(st[1], RANK_ACTIVE);
      rreq = 0;
      rdone = 1;
      @(negedge clk);
      rdone = 0;
      @(negedge clk);
      chk(gnt, 1'b0);
      chk(st[0], RANK_PD);
      pdm = 2'h2;
      issue(1'b0, 13'h0077);
      wst(0, RANK_CLOSE);
      chk(pca[0], 1'b1);
      chk(pins.cke[0], 1'b1);
      wst(0, RANK_PD);
      unu = 2'h2;
      tsen = 1;
      #1;
      chk(pins.cs_oe, 2'h1);
      chk(pins.ck_oe, 2'h1);
      chk(rxe, 2'h1);
      @(negedge clk);
      chk({ckp[1], ckn[1], ckp[0] ^ ckn[0]}, 16'h0001);
      unu = '0;
      tsen = 0;
      $display("test refresh, precharge and unused done");
      pdm = '0;
      issue(1'b0, 13'h0011);
      issue(1'b1, 13'h0022);
      gfx = 2'h2;
      // A queued transaction must hold back self-refresh in a deep state
      pend = 2'h1;
      cst = 4'h3;
      repeat (4) @(negedge clk);
      chk(flq, 1'b0);
      pend = '0;
      n = 0;
      while (flq !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      chk(flq, 1'b1);
      fdone = 1;
      @(negedge clk);
      fdone = 0;
      wst(0, RANK_SR);
      chk(st[1], RANK_ACTIVE);
      // Gating starts only once clock-enable has settled low
      @(negedge clk);
      chk(pins.cke, 2'h2);
      gate = 1;
      repeat (4) @(negedge clk);
      chk(pins.cke, 2'h2);
      gate = 0;
      cst = '0;
      wst(0, RANK_ACTIVE);
      repeat (2) @(negedge clk);
      chk(pins.cke, 2'h3);
      chk(16'(trl_cnt), 16'h0001);
      $display("test self-refresh done");
      give_verdict();
   end
endmodule // tb_dram_rank_power_manager
